//--- hw/rtctw_top.sv
// Time trimming, weekday counter and two weekly alarm comparators.
//
// Functional notes
// - Crystal select 0 picks 32.768 kHz (default), 1 picks 32.000 kHz.
// - Trim applies only in seconds 00, 20 and 40.
// - Untrimmed second lasts 32768 pulses, or 32000 with other crystal.
// - Direction 0 lengthens the second by (magnitude-1)*2 pulses.
// - Direction 1 shortens the second by (~magnitude+1)*2 pulses.
// - Magnitude bits five to one all zero leaves the count unchanged.
// - The 32 kHz clock output stays untrimmed, straight from oscillator.
// - Alarm A at addresses 8h-Ah, alarm B at Bh-Dh.
// - Hour bit five is PM flag or twenty-hour bit by mode.
// - In 12-hour mode midnight is 12 and noon is 32.
// - Weekday mask bit n enables weekday counter value n.
// - All mask bits zero means the alarm never fires.
// - After oscillator stop alarm contents undefined, upper bits read zero.
// - Enable clear disables the alarm and its flag reads zero.
// - Trim register at 7h, crystal select in bit 7, cleared on stop.
// - Weekday counts 0 to 6, one step per day carry, and wraps from 6 to 0.
`timescale 1ns/1ps
module rtctw_top
	import rtctw_pkg::*;
(
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst,
	// Oscillator pin and untrimmed clock output
	input  wire logic       osc_in,
	output logic            clk_32k_out,
	// Internal register port
	input  wire logic [3:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	// Timekeeping counters
	input  wire logic [6:0] seconds_bcd,
	input  wire logic [6:0] minutes_bcd,
	input  wire logic [5:0] hours_code,
	input  wire logic       day_carry,
	// Status and control
	input  wire logic       oscillator_stop_flag,
	input  wire logic       alarm_a_enable,
	input  wire logic       alarm_b_enable,
	// Results
	output logic            sec_tick,
	output logic      [2:0] weekday_count,
	output logic            alarm_a_flag,
	output logic            alarm_b_flag,
	output logic            alarm_a_hit,
	output logic            alarm_b_hit
);

	// ==========================================================
	// Helper functions

	// Alarm comparison shared by both alarm channels.
	function automatic logic alarm_match(
		input logic [6:0] am,
		input logic [5:0] ah,
		input logic [6:0] aw,
		input logic [6:0] cm,
		input logic [5:0] ch,
		input logic [2:0] cw
	);
		logic day_ok;
		day_ok = 1'b0;
		if (cw <= WEEKDAY_LAST) begin
			day_ok = aw[cw];
		end
		return day_ok && (am == cm) && (ah == ch);
	endfunction

	// Address decode used by the write paths; the read path decodes with a case.
	function automatic logic hits(
		input logic [3:0] a,
		input logic [3:0] target
	);
		return a == target;
	endfunction

	// ==========================================================
	// Oscillator synchroniser

	logic osc_s1_reg;
	logic osc_s2_reg;
	logic osc_s3_reg;
	logic osc_edge;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			osc_s1_reg <= 1'b0;
			osc_s2_reg <= 1'b0;
			osc_s3_reg <= 1'b0;
		end else begin
			osc_s1_reg <= osc_in;
			osc_s2_reg <= osc_s1_reg;
			osc_s3_reg <= osc_s2_reg;
		end
	end

	assign osc_edge = osc_s2_reg && !osc_s3_reg;

	// The output copy bypasses the trim counter on purpose.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			clk_32k_out <= 1'b0;
		end else begin
			clk_32k_out <= osc_s2_reg;
		end
	end

	// ==========================================================
	// Oscillator stop edge

	logic stop_prev_reg;
	logic stop_rise;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			stop_prev_reg <= 1'b0;
		end else begin
			stop_prev_reg <= oscillator_stop_flag;
		end
	end

	assign stop_rise = oscillator_stop_flag && !stop_prev_reg;

	// ==========================================================
	// Trim register

	logic [7:0] trim_reg;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			trim_reg <= TRIM_RESET;
		end else if (stop_rise) begin
			trim_reg <= TRIM_RESET;
		end else if (reg_wr && hits(reg_addr, ADDR_TRIM)) begin
			trim_reg <= reg_wdata;
		end
	end

	// ==========================================================
	// Prescaler

	rtctw_pre_if pre_bus ();

	assign pre_bus.osc_edge       = osc_edge;
	assign pre_bus.crystal_select = trim_reg[TRIM_XTAL_BIT];
	assign pre_bus.trim_direction = trim_reg[TRIM_DIR_BIT];
	assign pre_bus.trim_magnitude = trim_reg[5:0];
	assign pre_bus.seconds_bcd    = seconds_bcd;
	assign sec_tick               = pre_bus.sec_tick;

	rtctw_prescaler u_pre (
		.ref_clk (ref_clk),
		.rst     (rst),
		.p       (pre_bus)
	);

	// ==========================================================
	// Weekday counter

	logic [2:0] weekday_reg;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			weekday_reg <= WEEKDAY_FIRST;
		end else if (reg_wr && hits(reg_addr, ADDR_WEEKDAY)) begin
			weekday_reg <= reg_wdata[2:0];
		end else if (day_carry) begin
			if (weekday_reg >= WEEKDAY_LAST) begin
				weekday_reg <= WEEKDAY_FIRST;
			end else begin
				weekday_reg <= weekday_reg + 3'h1;
			end
		end
	end

	assign weekday_count = weekday_reg;

	// ==========================================================
	// Alarm registers

	// Contents are not reset: after a stop they are simply undefined,
	// but only the implemented bits exist, so upper bits stay zero.
	logic [6:0] alarm_a_minute_bcd;
	logic [5:0] alarm_a_hour_reg;
	logic [6:0] alarm_a_weekday_bits;
	logic [6:0] alarm_b_minute_bcd;
	logic [5:0] alarm_b_hour_reg;
	logic [6:0] alarm_b_weekday_bits;

	always_ff @(posedge ref_clk) begin
		if (reg_wr && hits(reg_addr, ADDR_A_MINUTE)) begin
			alarm_a_minute_bcd <= reg_wdata[6:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reg_wr && hits(reg_addr, ADDR_A_HOUR)) begin
			alarm_a_hour_reg <= reg_wdata[5:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reg_wr && hits(reg_addr, ADDR_A_WEEKDAY)) begin
			alarm_a_weekday_bits <= reg_wdata[6:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reg_wr && hits(reg_addr, ADDR_B_MINUTE)) begin
			alarm_b_minute_bcd <= reg_wdata[6:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reg_wr && hits(reg_addr, ADDR_B_HOUR)) begin
			alarm_b_hour_reg <= reg_wdata[5:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reg_wr && hits(reg_addr, ADDR_B_WEEKDAY)) begin
			alarm_b_weekday_bits <= reg_wdata[6:0];
		end
	end

	// ==========================================================
	// Alarm comparators

	logic match_a;
	logic match_b;
	logic prev_a_reg;
	logic prev_b_reg;

	always_comb begin
		match_a = alarm_a_enable && alarm_match(alarm_a_minute_bcd,
			alarm_a_hour_reg, alarm_a_weekday_bits, minutes_bcd,
			hours_code, weekday_reg);
		match_b = alarm_b_enable && alarm_match(alarm_b_minute_bcd,
			alarm_b_hour_reg, alarm_b_weekday_bits, minutes_bcd,
			hours_code, weekday_reg);
	end

	// An impossible alarm time never equals the counters and stays quiet.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			prev_a_reg  <= 1'b0;
			alarm_a_hit <= 1'b0;
		end else begin
			prev_a_reg  <= match_a;
			alarm_a_hit <= match_a && !prev_a_reg;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			prev_b_reg  <= 1'b0;
			alarm_b_hit <= 1'b0;
		end else begin
			prev_b_reg  <= match_b;
			alarm_b_hit <= match_b && !prev_b_reg;
		end
	end

	// Match levels; forced low whenever the alarm is disabled.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			alarm_a_flag <= 1'b0;
			alarm_b_flag <= 1'b0;
		end else begin
			alarm_a_flag <= match_a;
			alarm_b_flag <= match_b;
		end
	end

	// ==========================================================
	// Read path

	logic [7:0] rd_mux;

	always_comb begin
		rd_mux = 8'h00;
		unique case (reg_addr)
			ADDR_WEEKDAY:   rd_mux = {5'h00, weekday_reg};
			ADDR_TRIM:      rd_mux = trim_reg;
			ADDR_A_MINUTE:  rd_mux = {1'b0, alarm_a_minute_bcd};
			ADDR_A_HOUR:    rd_mux = {2'h0, alarm_a_hour_reg};
			ADDR_A_WEEKDAY: rd_mux = {1'b0, alarm_a_weekday_bits};
			ADDR_B_MINUTE:  rd_mux = {1'b0, alarm_b_minute_bcd};
			ADDR_B_HOUR:    rd_mux = {2'h0, alarm_b_hour_reg};
			ADDR_B_WEEKDAY: rd_mux = {1'b0, alarm_b_weekday_bits};
			default:        rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= rd_mux;
		end
	end

endmodule

//--- hw/rtctw_pkg.sv
// Package with addresses, field layouts, reset values and counts for trimming and alarms.
package rtctw_pkg;

	// ==========================================================
	// Internal register addresses
	localparam logic [3:0] ADDR_WEEKDAY   = 4'h3;
	localparam logic [3:0] ADDR_TRIM      = 4'h7;
	localparam logic [3:0] ADDR_A_MINUTE  = 4'h8;
	localparam logic [3:0] ADDR_A_HOUR    = 4'h9;
	localparam logic [3:0] ADDR_A_WEEKDAY = 4'hA;
	localparam logic [3:0] ADDR_B_MINUTE  = 4'hB;
	localparam logic [3:0] ADDR_B_HOUR    = 4'hC;
	localparam logic [3:0] ADDR_B_WEEKDAY = 4'hD;

	// ==========================================================
	// Field layouts
	localparam int TRIM_XTAL_BIT = 7;
	localparam int TRIM_DIR_BIT = 6;
	localparam int HOUR_PM_BIT  = 5;
	localparam logic [7:0] MINUTE_MASK  = 8'h7F;
	localparam logic [7:0] HOUR_MASK    = 8'h3F;
	localparam logic [7:0] WEEKMASK_MASK = 8'h7F;
	localparam logic [7:0] WEEKDAY_MASK = 8'h07;

	// ==========================================================
	// Reset values and counts
	localparam logic [7:0]  TRIM_RESET    = 8'h00;
	localparam logic [2:0]  WEEKDAY_LAST  = 3'h6;
	localparam logic [2:0]  WEEKDAY_FIRST = 3'h0;
	localparam logic [15:0] NOM_32768     = 16'h8000;
	localparam logic [15:0] NOM_32000     = 16'h7D00;
	localparam logic [6:0]  TRIM_SEC_00   = 7'h00;
	localparam logic [6:0]  TRIM_SEC_20   = 7'h20;
	localparam logic [6:0]  TRIM_SEC_40   = 7'h40;

	// Oscillator pulses in the current second.
	function automatic logic [15:0] rtctw_second_len(
		input logic       xtal,
		input logic       dir,
		input logic [5:0] mag,
		input logic [6:0] sec
	);
		logic [15:0] nom;
		logic [6:0]  adj;
		logic        tsec;
		nom  = xtal ? NOM_32000 : NOM_32768;
		tsec = (sec == TRIM_SEC_00) || (sec == TRIM_SEC_20) ||
		       (sec == TRIM_SEC_40);
		adj  = 7'h00;
		if (!tsec || mag[5:1] == 5'h00) begin
			return nom;
		end
		if (!dir) begin
			adj = {1'b0, mag} - 7'h01;
			return nom + {8'h00, adj, 1'b0};
		end
		adj = {1'b0, ~mag} + 7'h01;
		return nom - {8'h00, adj, 1'b0};
	endfunction

endpackage

//--- hw/rtctw_pre_if.sv
// Interface between the register side and the trimmed one-second prescaler.
`timescale 1ns/1ps
interface rtctw_pre_if;
	logic       osc_edge;
	logic       crystal_select;
	logic       trim_direction;
	logic [5:0] trim_magnitude;
	logic [6:0] seconds_bcd;
	logic       sec_tick;

	modport ctl (
		output osc_edge,
		output crystal_select,
		output trim_direction,
		output trim_magnitude,
		output seconds_bcd,
		input  sec_tick
	);
	modport pre (
		input  osc_edge,
		input  crystal_select,
		input  trim_direction,
		input  trim_magnitude,
		input  seconds_bcd,
		output sec_tick
	);
endinterface

//--- hw/rtctw_prescaler.sv
// Trimmed prescaler turning oscillator pulses into one-second ticks.
`timescale 1ns/1ps
module rtctw_prescaler
	import rtctw_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Control side
	rtctw_pre_if.pre p
);

	// ==========================================================
	// Pulse counter
	logic [15:0] cnt_reg;
	logic [15:0] len;
	logic        tick_reg;

	always_comb begin
		len = rtctw_second_len(p.crystal_select, p.trim_direction,
		                       p.trim_magnitude, p.seconds_bcd);
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cnt_reg <= 16'h0000;
		end else if (p.osc_edge) begin
			if (cnt_reg >= len - 16'h0001) begin
				cnt_reg <= 16'h0000;
			end else begin
				cnt_reg <= cnt_reg + 16'h0001;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			tick_reg <= 1'b0;
		end else begin
			tick_reg <= p.osc_edge && (cnt_reg >= len - 16'h0001);
		end
	end

	assign p.sec_tick = tick_reg;

endmodule

//--- dv/rtctw_osc_model.sv
// Crystal stand-in that drives the oscillator pin.
`timescale 1ns/1ps
module rtctw_osc_model (
	// Clock and enable
	input  wire logic ref_clk,
	input  wire logic run,
	// Oscillator pin
	output logic      osc
);
	// One pulse every two clocks keeps a full second short to simulate.
	always_ff @(posedge ref_clk) begin
		osc <= run && !osc;
	end
endmodule

//--- dv/rtctw_assertions.sv
// Checker for clock output, weekday and alarm A behaviour at the top ports.
`timescale 1ns/1ps
module rtctw_assertions
	import rtctw_pkg::*;
(
	// Clock and reset
	input wire logic       ref_clk,
	input wire logic       rst,
	// Pins and register port
	input wire logic       osc_in,
	input wire logic       clk_32k_out,
	input wire logic [3:0] reg_addr,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	// Counters and results
	input wire logic [6:0] minutes_bcd,
	input wire logic [5:0] hours_code,
	input wire logic       day_carry,
	input wire logic       alarm_a_enable,
	input wire logic       sec_tick,
	input wire logic [2:0] weekday_count,
	input wire logic       alarm_a_flag,
	input wire logic       alarm_a_hit
);
	// ==========================================================
	// Shadow of alarm A, upper bits dropped as the device does.
	logic [6:0] am_reg;
	logic [5:0] ah_reg;
	logic [6:0] aw_reg;
	logic       match_a;
	logic       wd_wr;
	always_ff @(posedge ref_clk) begin
		if (reg_wr && reg_addr == ADDR_A_MINUTE) am_reg <= reg_wdata[6:0];
		if (reg_wr && reg_addr == ADDR_A_HOUR) ah_reg <= reg_wdata[5:0];
		if (reg_wr && reg_addr == ADDR_A_WEEKDAY) aw_reg <= reg_wdata[6:0];
	end
	assign match_a = alarm_a_enable && aw_reg[weekday_count] &&
		minutes_bcd == am_reg && hours_code == ah_reg;
	assign wd_wr = reg_wr && reg_addr == ADDR_WEEKDAY;

	// ==========================================================
	// Properties
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	a_clkout_raw: assert property (clk_32k_out == $past(osc_in, 3))
		else $error("Clock output is not the delayed oscillator.");
	a_alarm_match: assert property (alarm_a_flag == $past(match_a))
		else $error("Alarm flag disagrees with the compare.");
	a_mask_zero: assert property (aw_reg == 7'h00 |=> !alarm_a_flag)
		else $error("Alarm fired with an empty mask.");
	a_enable_off: assert property (!alarm_a_enable |=> !alarm_a_flag)
		else $error("Alarm flag set while disabled.");
	a_hit_rise: assert property ($rose(alarm_a_flag) |-> alarm_a_hit)
		else $error("No hit when the match began.");
	a_hit_once: assert property (alarm_a_hit |=> !alarm_a_hit)
		else $error("Hit lasted over one cycle.");
	a_weekday_wrap: assert property (day_carry && !wd_wr &&
		weekday_count == WEEKDAY_LAST |=> weekday_count == WEEKDAY_FIRST)
		else $error("Weekday did not wrap.");
	a_weekday_step: assert property (day_carry && !wd_wr &&
		weekday_count < WEEKDAY_LAST |=>
		weekday_count == $past(weekday_count) + 3'h1)
		else $error("Weekday did not advance.");
	a_unmapped_zero: assert property (reg_rd && (reg_addr > ADDR_B_WEEKDAY ||
		reg_addr < ADDR_WEEKDAY) |=> reg_rdata == 8'h00)
		else $error("Foreign address read non-zero.");
	a_tick_single: assert property (sec_tick |=> !sec_tick)
		else $error("Second tick lasted over one cycle.");
endmodule

bind rtctw_top rtctw_assertions u_chk (.ref_clk, .rst, .osc_in, .clk_32k_out,
	.reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .minutes_bcd,
	.hours_code, .day_carry, .alarm_a_enable, .sec_tick, .weekday_count,
	.alarm_a_flag, .alarm_a_hit);

//--- dv/tb_top.sv
// Self-checking bench for the trimming and weekly alarm block.
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin \
	miscompares++; $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module tb_top
	import rtctw_pkg::*;
();
	logic       ref_clk, rst, run, osc_in, reg_wr, reg_rd, day_carry, osf;
	logic       a_en, b_en, a_flag, b_flag, sec_tick, b_hit;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata;
	logic [6:0] secs, mins;
	logic [5:0] hours;
	int         miscompares, cmp_count, n;
	logic [7:0] upper_exp [6] = '{MINUTE_MASK, HOUR_MASK, WEEKMASK_MASK,
		MINUTE_MASK, HOUR_MASK, WEEKMASK_MASK};

	rtctw_top dut (.ref_clk, .rst, .osc_in, .clk_32k_out(), .reg_addr,
		.reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .seconds_bcd(secs),
		.minutes_bcd(mins), .hours_code(hours), .day_carry,
		.oscillator_stop_flag(osf), .alarm_a_enable(a_en),
		.alarm_b_enable(b_en), .sec_tick, .weekday_count(),
		.alarm_a_flag(a_flag), .alarm_b_flag(b_flag), .alarm_a_hit(),
		.alarm_b_hit(b_hit));
	rtctw_osc_model osc_m (.ref_clk, .run, .osc(osc_in));

	// ==========================================================
	// Access tasks
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(posedge ref_clk);
		@(negedge ref_clk);
		`CHK(reg_rdata, e)
		@(posedge ref_clk);
	endtask
	task automatic flags(input logic ea, input logic eb);
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk);
		`CHK(a_flag, ea)
		`CHK(b_flag, eb)
		@(posedge ref_clk);
	endtask
	task automatic carry();
		day_carry <= 1'b1;
		@(posedge ref_clk);
		day_carry <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic wrap_up();
		if (miscompares == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// ==========================================================
	// Tests
	initial begin
		{run, reg_wr, reg_rd, day_carry, osf, a_en, b_en} = '0;
		{reg_addr, reg_wdata, secs, mins, hours} = '0;
		rst = 1'b1;
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		rd(ADDR_TRIM, TRIM_RESET);
		for (n = 0; n < 6; n++) begin
			wr(ADDR_A_MINUTE + 4'(n), 8'hFF);
			rd(ADDR_A_MINUTE + 4'(n), upper_exp[n]);
		end
		// Each zero read follows a non-zero one, so stale data would fail.
		rd(4'h0, 8'h00);
		wr(ADDR_TRIM, 8'h81);
		rd(ADDR_TRIM, 8'h81);
		rd(4'hF, 8'h00);
		rd(ADDR_TRIM, 8'h81);
		osf <= 1'b1;
		@(posedge ref_clk);
		osf <= 1'b0;
		@(posedge ref_clk);
		rd(ADDR_TRIM, TRIM_RESET);
		wr(ADDR_WEEKDAY, 8'h05);
		carry();
		rd(ADDR_WEEKDAY, 8'h06);
		carry();
		rd(ADDR_WEEKDAY, 8'h00);
		// Reachable times only, so every compare below can really match.
		wr(ADDR_WEEKDAY, 8'h01);
		wr(ADDR_A_MINUTE, 8'h30);
		wr(ADDR_A_HOUR, 8'h21);
		wr(ADDR_A_WEEKDAY, 8'h02);
		mins  <= 7'h30;
		hours <= 6'h21;
		a_en  <= 1'b1;
		flags(1'b1, 1'b0);
		a_en <= 1'b0;
		flags(1'b0, 1'b0);
		a_en <= 1'b1;
		wr(ADDR_A_WEEKDAY, 8'h01);
		flags(1'b0, 1'b0);
		wr(ADDR_A_WEEKDAY, 8'h00);
		flags(1'b0, 1'b0);
		wr(ADDR_B_MINUTE, 8'h00);
		wr(ADDR_B_HOUR, 8'h32);
		wr(ADDR_B_WEEKDAY, 8'h7F);
		mins  <= 7'h00;
		hours <= 6'h32;
		b_en  <= 1'b1;
		@(posedge ref_clk);
		@(negedge ref_clk);
		`CHK(b_hit, 1'b1)
		@(negedge ref_clk);
		`CHK(b_hit, 1'b0)
		flags(1'b0, 1'b1);
		wr(ADDR_TRIM, 8'hC2);
		secs <= TRIM_SEC_20;
		run  <= 1'b1;
		n = 0;
		while (sec_tick !== 1'b1 && n < 70000) begin
			@(negedge ref_clk);
			n++;
		end
		`CHK(n > 2 * (32000 - 124) - 4 && n < 2 * (32000 - 124) + 10, 1'b1)
		wrap_up();
	end

	initial begin
		repeat (90000) @(posedge ref_clk);
		miscompares++;
		wrap_up();
	end
endmodule
